// >>> flag_pkg.sv
package flag_pkg;

    // Flag word bit positions.
    localparam int CARRY_BIT = 0;
    localparam int FIXED_ONE_BIT = 1;
    localparam int PARITY_BIT = 2;
    localparam int NIBBLE_BIT = 4;
    localparam int ZERO_BIT = 6;
    localparam int SIGN_BIT = 7;
    localparam int STEP_BIT = 8;
    localparam int IRQ_EN_BIT = 9;
    localparam int DIR_BIT = 10;
    localparam int OVF_BIT = 11;
    localparam int IO_PRIVILEGE_LIMIT_LO = 12;
    localparam int IO_PRIVILEGE_LIMIT_HI = 13;

    // Bits held by the flag word; the rest of a saved image is forced.
    localparam logic [31:0] DEFINED_MASK = 32'h0007_7fd5;
    localparam logic [31:0] FIXED_ONES = 32'h0000_0002;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] RESULT_MASK = 32'h0000_08d5;
    localparam logic [31:0] IRQ_EN_MASK = 32'h0000_0200;
    localparam logic [31:0] IO_PRIVILEGE_LIMIT_MASK = 32'h0000_3000;

    // Register map of the plain register port.
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CLEAR = 8'h08;
    localparam logic [7:0] OFF_ENABLE = 8'h0c;

    // Event bits of the status, clear and enable registers.
    localparam int EV_OVF = 0;
    localparam int EV_DEBUG = 1;
    localparam int EV_IRQ = 2;
    localparam int EV_N = 3;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_DWORD = 2'b10
    } op_size_t;

    typedef enum logic [1:0] {
        OP_ADD = 2'b00,
        OP_SUB = 2'b01,
        OP_LOGIC = 2'b10
    } op_kind_t;

    function automatic logic [4:0] top_bit(input logic [1:0] size);
        case (size)
            SIZE_BYTE: top_bit = 5'h07;
            SIZE_WORD: top_bit = 5'h0f;
            default: top_bit = 5'h1f;
        endcase
    endfunction

    function automatic logic [31:0] size_mask(input logic [1:0] size);
        case (size)
            SIZE_BYTE: size_mask = 32'h0000_00ff;
            SIZE_WORD: size_mask = 32'h0000_ffff;
            default: size_mask = 32'hffff_ffff;
        endcase
    endfunction

endpackage

// >>> result_flag_calc.sv
`timescale 1ns/1ps
module result_flag_calc (
    input wire logic [1:0] op_size,
    input wire logic [1:0] op_kind,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic [31:0] op_result,
    output logic ovf,
    output logic sign,
    output logic zero,
    output logic nibble,
    output logic parity,
    output logic carry
);
    logic [4:0] top;
    logic [31:0] into_vec;
    logic arith;
    logic is_sub;
    logic c_in;
    logic c_out;
    logic a_t;
    logic b_t;

    // The carry (or borrow) into each bit is recovered from both operands
    // and the sum, so the datapath need not export its carry chain.
    assign top = flag_pkg::top_bit(op_size);
    assign into_vec = op_a ^ op_b ^ op_result;
    assign arith = (op_kind == flag_pkg::OP_ADD) ||
                   (op_kind == flag_pkg::OP_SUB);
    assign is_sub = (op_kind == flag_pkg::OP_SUB);
    assign a_t = op_a[top];
    assign b_t = op_b[top];
    assign c_in = into_vec[top];
    assign c_out = is_sub ? ((~a_t & b_t) | (c_in & ~(a_t ^ b_t)))
                          : ((a_t & b_t) | (c_in & (a_t ^ b_t)));
    assign ovf = arith & (c_in ^ c_out);  // see RQ1, see RQ2
    assign sign = op_result[top];  // see RQ8, see RQ9
    assign zero = ~|(op_result & flag_pkg::size_mask(op_size));  // see RQ10
    assign nibble = arith & into_vec[4];  // see RQ11
    assign parity = ~^op_result[7:0];  // see RQ12
    assign carry = arith & c_out;  // see RQ13, see RQ14

endmodule

// >>> status_flag_logic.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
// Function
// RQ1: Overflow set when carry in differs out.
// RQ2: Overflow taken at bit 7, 15, 31.
// RQ3: Direction bit selects index increment or decrement.
// RQ4: Interrupt-enable bit gates the maskable pin.
// RQ5: Image load changes enable only if privileged.
// RQ6: Step bit traps after next instruction.
// RQ7: Otherwise debug trap only from breakpoints.
// RQ8: Sign flag copies result top bit.
// RQ9: Sign taken at bit 7, 15, 31.
// RQ10: Zero flag set when result all zero.
// RQ11: Nibble carry records bit 3 carry.
// RQ12: Parity flag even over low byte.
// RQ13: Carry flag records top-bit carry or borrow.
// RQ14: Carry taken at bit 7, 15, 31.
// RQ15: Saved word has bit 1 one, others zero.
// RQ16: Flags update in the commit cycle.
module status_flag_logic (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic op_commit,
    input wire logic [1:0] op_size,
    input wire logic [1:0] op_kind,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic [31:0] op_result,
    input wire logic image_load,
    input wire logic [31:0] image_data,
    input wire logic [1:0] current_privilege,
    input wire logic maskable_irq_pin,
    input wire logic instr_done,
    input wire logic bp_match,
    output logic [31:0] status_flags_word,
    output logic index_decrement,
    output logic irq_accept,
    output logic debug_exception,
    output logic irq
);
    localparam int NE = flag_pkg::EV_N;

    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic [NE-1:0] status_q;
    logic [NE-1:0] status_d;
    logic [NE-1:0] enable_q;
    logic [31:0] rdata_q;
    logic dir_q;
    logic accept_q;
    logic debug_q;
    logic irq_q;
    logic pin_s1_q;
    logic pin_s2_q;

    logic f_ovf;
    logic f_sign;
    logic f_zero;
    logic f_nibble;
    logic f_parity;
    logic f_carry;

    result_flag_calc calc (
        .op_size(op_size),
        .op_kind(op_kind),
        .op_a(op_a),
        .op_b(op_b),
        .op_result(op_result),
        .ovf(f_ovf),
        .sign(f_sign),
        .zero(f_zero),
        .nibble(f_nibble),
        .parity(f_parity),
        .carry(f_carry)
    );

    // Result flags assembled at their word positions.
    wire [31:0] result_vec = {20'h0_0000, f_ovf, 3'h0, f_sign, f_zero,
                              1'b0, f_nibble, 1'b0, f_parity, 1'b0, f_carry};
    wire [31:0] arith_img = (flags_q & ~flag_pkg::RESULT_MASK) | result_vec;

    // A stacked image may not raise privilege: the enable bit follows the
    // image only at sufficient privilege, the privilege field only at zero.
    wire [1:0] io_privilege_limit_cur = flags_q[flag_pkg::IO_PRIVILEGE_LIMIT_HI:flag_pkg::IO_PRIVILEGE_LIMIT_LO];
    wire may_set_if = current_privilege <= io_privilege_limit_cur;  // see RQ5
    wire may_set_io_privilege_limit = current_privilege == 2'b00;
    wire [31:0] pop_mask = flag_pkg::DEFINED_MASK
        & ~(may_set_if ? 32'h0000_0000 : flag_pkg::IRQ_EN_MASK)
        & ~(may_set_io_privilege_limit ? 32'h0000_0000 : flag_pkg::IO_PRIVILEGE_LIMIT_MASK);
    wire [31:0] pop_img = (image_data & pop_mask)
        | (flags_q & flag_pkg::DEFINED_MASK & ~pop_mask)
        | flag_pkg::FIXED_ONES;  // see RQ15

    wire sel_flags = reg_addr == flag_pkg::OFF_FLAGS;
    wire sel_status = reg_addr == flag_pkg::OFF_STATUS;
    wire sel_clear = reg_addr == flag_pkg::OFF_CLEAR;
    wire sel_enable = reg_addr == flag_pkg::OFF_ENABLE;

    wire [31:0] wr_img = (reg_wdata & flag_pkg::DEFINED_MASK)
        | flag_pkg::FIXED_ONES;  // see RQ15

    // Stack loads beat result updates, which beat software writes; the
    // sequencer never loads and commits in one cycle in practice.
    assign flags_d = image_load ? pop_img :
                     op_commit ? arith_img :  // see RQ16
                     (reg_wr && sel_flags) ? wr_img : flags_q;

    // Trap after the instruction that began with the step bit set.
    wire step_trap = instr_done & flags_q[flag_pkg::STEP_BIT];  // see RQ6
    wire debug_d = step_trap | bp_match;  // see RQ7
    wire accept_d = pin_s2_q & flags_q[flag_pkg::IRQ_EN_BIT];  // see RQ4

    wire [NE-1:0] events = {accept_d, debug_d,
                            op_commit & ~image_load & f_ovf};
    wire [NE-1:0] clr = (reg_wr && sel_clear) ? reg_wdata[NE-1:0] : '0;
    // A new event in the clearing cycle survives the clear.
    assign status_d = (status_q & ~clr) | events;

    wire [31:0] rd_mux = sel_flags ? flags_q :
                         sel_status ? {29'h0, status_q} :
                         sel_enable ? {29'h0, enable_q} : 32'h0000_0000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_q <= flag_pkg::FLAGS_RESET;
            dir_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            dir_q <= flags_d[flag_pkg::DIR_BIT];  // see RQ3
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_q <= '0;
            enable_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (reg_wr && sel_enable) begin
                enable_q <= reg_wdata[NE-1:0];
            end
            irq_q <= |(status_d & enable_q);
        end
    end

    // The pin is asynchronous to the core clock.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            accept_q <= 1'b0;
            debug_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            pin_s1_q <= maskable_irq_pin;
            pin_s2_q <= pin_s1_q;
            accept_q <= accept_d;
            debug_q <= debug_d;
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign status_flags_word = flags_q;
    assign index_decrement = dir_q;
    assign irq_accept = accept_q;
    assign debug_exception = debug_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_irq_gate: assert property (  // see RQ4
        irq_accept |-> $past(flags_q[flag_pkg::IRQ_EN_BIT]) && $past(pin_s2_q)
    ) else $error("Interrupt accepted while masked.");

    a_dir_follow: assert property (  // see RQ3
        index_decrement == flags_q[flag_pkg::DIR_BIT]
    ) else $error("Index direction differs from flag.");

    a_if_guard: assert property (  // see RQ5
        image_load && current_privilege > io_privilege_limit_cur
        |=> flags_q[flag_pkg::IRQ_EN_BIT]
            == $past(flags_q[flag_pkg::IRQ_EN_BIT])
    ) else $error("Unprivileged load altered interrupt enable.");

    a_step_trap: assert property (  // see RQ6
        instr_done && flags_q[flag_pkg::STEP_BIT] |=> debug_exception
    ) else $error("Single step trap missing.");

    a_no_trap: assert property (  // see RQ7
        !bp_match && !(instr_done && flags_q[flag_pkg::STEP_BIT])
        |=> !debug_exception
    ) else $error("Debug exception without cause.");

    a_sign_copy: assert property (  // see RQ9
        op_commit && !image_load
        |=> flags_q[flag_pkg::SIGN_BIT]
            == $past(op_result[flag_pkg::top_bit(op_size)])
    ) else $error("Sign flag not from result top bit.");

    a_zero_flag: assert property (  // see RQ10
        op_commit && !image_load
        |=> flags_q[flag_pkg::ZERO_BIT]
            == $past((op_result & flag_pkg::size_mask(op_size)) == 32'h0)
    ) else $error("Zero flag wrong.");

    a_parity_low: assert property (  // see RQ12
        op_commit && !image_load
        |=> flags_q[flag_pkg::PARITY_BIT] == ~^$past(op_result[7:0])
    ) else $error("Parity flag wrong.");

    a_fixed_bits: assert property (  // see RQ15
        (flags_q & ~flag_pkg::DEFINED_MASK) == flag_pkg::FIXED_ONES
    ) else $error("Reserved flag bits not at fixed values.");

    a_ovf_event: assert property (  // see RQ1
        op_commit && !image_load && f_ovf
        |=> flags_q[flag_pkg::OVF_BIT] && status_q[flag_pkg::EV_OVF]
    ) else $error("Overflow not recorded.");

endmodule

// >>> exec_model.sv
`timescale 1ns/1ps
module exec_model (
    input wire logic [1:0] op_kind,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    output logic [31:0] op_result
);
    // The result stays full width, because the flag block narrows it itself.
    assign op_result = (op_kind == flag_pkg::OP_ADD) ? op_a + op_b :
        (op_kind == flag_pkg::OP_SUB) ? op_a - op_b : op_a & op_b;
endmodule

// >>> test_status_flag_logic.sv
`timescale 1ns/1ps
module test_status_flag_logic;
    logic clk, reset, reg_wr, reg_rd, op_commit, image_load;
    logic maskable_irq_pin, instr_done, bp_match;
    logic index_decrement, irq_accept, debug_exception, irq;
    logic [7:0] reg_addr;
    logic [1:0] op_size, op_kind, current_privilege;
    logic [31:0] reg_wdata, reg_rdata, op_a, op_b, op_result;
    logic [31:0] image_data, status_flags_word;
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] ta [5] = '{32'h0000_00ff, 32'h0000_007f, 32'h0000_0000,
        32'h7fff_ffff, 32'h0000_00f0};
    logic [31:0] tb [5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'hf};
    logic [1:0] tk [5] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2};
    logic [1:0] ts [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [31:0] te [5] = '{32'h0000_0057, 32'h0000_0892, 32'h0000_0097,
        32'h0000_0896, 32'h0000_0046};

    always #2 clk = ~clk;

    exec_model exec_model_i (.op_kind(op_kind), .op_a(op_a), .op_b(op_b),
        .op_result(op_result));
    status_flag_logic status_flag_logic_i (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_commit(op_commit),
        .op_size(op_size), .op_kind(op_kind), .op_a(op_a), .op_b(op_b),
        .op_result(op_result), .image_load(image_load),
        .image_data(image_data), .current_privilege(current_privilege),
        .maskable_irq_pin(maskable_irq_pin), .instr_done(instr_done),
        .bp_match(bp_match), .status_flags_word(status_flags_word),
        .index_decrement(index_decrement), .irq_accept(irq_accept),
        .debug_exception(debug_exception), .irq(irq));

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask

    task automatic commit(input int i);
        @(posedge clk);
        op_commit <= 1'b1;
        op_kind <= tk[i];
        op_size <= ts[i];
        op_a <= ta[i];
        op_b <= tb[i];
        @(posedge clk);
        op_commit <= 1'b0;
        #1;
    endtask

    task automatic load(input logic [1:0] priv, input logic [31:0] d);
        @(posedge clk);
        image_load <= 1'b1;
        current_privilege <= priv;
        image_data <= d;
        @(posedge clk);
        image_load <= 1'b0;
        #1;
    endtask

    task automatic step(input logic bp);
        @(posedge clk);
        instr_done <= ~bp;
        bp_match <= bp;
        @(posedge clk);
        instr_done <= 1'b0;
        bp_match <= 1'b0;
        #1;
    endtask

    initial begin
        #4000;
        n_errors++;
        conclude();
    end

    initial begin
        {clk, reg_wr, reg_rd, op_commit, image_load} = 5'h0;
        {maskable_irq_pin, instr_done, bp_match} = 3'h0;
        {reg_addr, reg_wdata, op_a, op_b, image_data} = 136'h0;
        {op_size, op_kind, current_privilege} = 6'h0;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1 chk("reset flags", 32'h0000_0002, status_flags_word);
        for (int i = 0; i < 5; i++) begin
            commit(i);
            chk("flags", te[i], status_flags_word);
            rd(flag_pkg::OFF_FLAGS, te[i], "flag read");
        end
        wr(flag_pkg::OFF_FLAGS, 32'h0000_0400);
        chk("decrement", 32'h1, {31'h0, index_decrement});
        wr(flag_pkg::OFF_FLAGS, 32'h0000_0000);
        chk("increment", 32'h0, {31'h0, index_decrement});
        @(posedge clk) maskable_irq_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("masked pin", 32'h0, {31'h0, irq_accept});
        wr(flag_pkg::OFF_FLAGS, 32'h0000_0200);
        repeat (4) @(posedge clk);
        #1 chk("taken pin", 32'h1, {31'h0, irq_accept});
        @(posedge clk) maskable_irq_pin <= 1'b0;
        load(2'h0, 32'h0000_0000);
        load(2'h3, 32'h0000_0200);
        chk("refused enable", 32'h0000_0002, status_flags_word);
        load(2'h0, 32'hffff_ffff);
        chk("loaded image", 32'h0007_7fd7, status_flags_word);
        load(2'h3, 32'h0000_0000);
        chk("allowed enable", 32'h0000_3002, status_flags_word);
        wr(flag_pkg::OFF_FLAGS, 32'h0000_0100);
        step(1'b0);
        chk("step trap", 32'h1, {31'h0, debug_exception});
        wr(flag_pkg::OFF_FLAGS, 32'h0000_0000);
        step(1'b0);
        chk("no trap", 32'h0, {31'h0, debug_exception});
        step(1'b1);
        chk("bp trap", 32'h1, {31'h0, debug_exception});
        rd(flag_pkg::OFF_STATUS, 32'h0000_0007, "status");
        wr(flag_pkg::OFF_ENABLE, 32'h0000_0002);
        repeat (2) @(posedge clk);
        #1 chk("irq raised", 32'h1, {31'h0, irq});
        rd(flag_pkg::OFF_ENABLE, 32'h0000_0002, "enable");
        wr(flag_pkg::OFF_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1 chk("irq masked", 32'h0, {31'h0, irq});
        wr(flag_pkg::OFF_CLEAR, 32'h0000_0007);
        rd(flag_pkg::OFF_STATUS, 32'h0000_0000, "cleared");
        wr(flag_pkg::OFF_ENABLE, 32'h0000_0007);
        repeat (2) @(posedge clk);
        #1 chk("irq after clear", 32'h0, {31'h0, irq});
        rd(8'h10, 32'h0000_0000, "unmapped");
        conclude();
    end
endmodule
